// >>> sdiltc_cfg.svh
/*
 * constants for the input select and loop-through control block.
 * assumes inclusion by bare name from the s2p, top and bench files.
 */
`ifndef SDILTC_CFG_SVH
`define SDILTC_CFG_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define SDILTC_A_CTRL      4'h0
`define SDILTC_A_STATUS    4'h4
`define SDILTC_DWELL_RST   16'h1000
`define SDILTC_OVF_BIT     6

// ---------------------------------------------------------------
// lock hunt and levels
// ---------------------------------------------------------------
`define SDILTC_HUNT_TRIES  2'h3
`define SDILTC_RATE_SD     1'b1
`define SDILTC_RESP_OK     2'h0
`define SDILTC_RESP_ERR    2'h2
`define SDILTC_WORD_W      20
`define SDILTC_NARROW_W    10
`define SDILTC_FIFO_DEPTH  16
// synchroniser flush value: both carrier pins read as absent, so no
// false carrier or unmuted cycle follows reset
`define SDILTC_SYNC_RST    9'h180

`endif

// >>> sdiltc_pkg.sv
/*
 * types shared by the control block.
 * assumes the cfg header for numeric constants.
 */
`default_nettype none
package sdiltc_pkg;
  typedef enum logic [3:0] {
    LS_IDLE = 4'b0001,
    LS_HUNT = 4'b0010,
    LS_LOCK = 4'b0100,
    LS_PLL  = 4'b1000
  } sdiltc_lock_t;
endpackage
`default_nettype wire

// >>> sdiltc_fifo.sv
/*
 * word fifo with valid/ready on both sides.
 * assumes a single clock and synchronous active-low reset.
 */
`default_nettype none
module sdiltc_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  always_comb begin
    in_ready  = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    out_data  = mem_q[rd_q];
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// >>> sdiltc_s2p.sv
/*
 * serial-to-parallel word former, 10 or 20 bits, lsb first.
 * assumes one reclocked bit per valid cycle from same-clock logic.
 */
`default_nettype none
`include "sdiltc_cfg.svh"
module sdiltc_s2p #(
  parameter int W = `SDILTC_WORD_W
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         bit_in,
  input  wire logic         bit_valid,
  input  wire logic         wide,
  output logic [W-1:0]      word,
  output logic              word_valid,
  input  wire logic         word_ready,
  output logic              drop
);
  logic [W-1:0] sh_q, sh_d, word_d;
  logic [4:0]   n_q, n_d;
  logic         full_q, full_d;
  logic [4:0]   lim;

  always_comb begin
    lim    = wide ? 5'(W) : 5'(`SDILTC_NARROW_W);
    sh_d   = sh_q;
    n_d    = n_q;
    full_d = full_q & ~word_ready;
    word_d = word;
    // a held word that is not taken costs the arriving bit
    drop   = bit_valid & full_q & ~word_ready;
    if (bit_valid && !drop) begin
      sh_d = {bit_in, sh_q[W-1:1]};
      n_d  = n_q + 5'h01;
      // >= so a narrowing width change mid-word cannot run past lim
      if (n_d >= lim) begin
        word_d = wide ? sh_d : {{(W/2){1'b0}}, sh_d[W-1 -: W/2]};
        full_d = 1'b1;
        n_d    = 5'h00;
      end
    end
  end

  assign word_valid = full_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q   <= '0;
      n_q    <= '0;
      full_q <= 1'b0;
      word   <= '0;
    end else begin
      sh_q   <= sh_d;
      n_q    <= n_d;
      full_q <= full_d;
      word   <= word_d;
    end
  end
endmodule
`default_nettype wire

// >>> sdiltc_top.sv
/*
 * input select, rate steering and loop-through control.
 * assumes pins arrive asynchronous; serial bits, sync_found and the
 * word consumers run on aclk; AXI4-Lite master on aclk.
 */
// Register access over AXI4-Lite and the address map were decided locally.
// Overview of operation
// - one active-low carrier pin per input
// - carrier selected by the input choose pin
// - choose high routes input one, low two
// - master hunt toggles rate between RATE_CHOOSE
// - slave rate follows rate choose pin only
// - reclocker lock indication fed to lock logic
// - enable low puts both outputs high-Z
// - slave bypass pin picks reclocked or buffered
// - master drives bypass high only when locked
// - invalid carrier mutes loop-through in both modes
// - slave reclocked but unlocked also mutes
// - lock output needs valid selected carrier
// - 10/20-bit words to both alignment paths
// - mode pin high master, low slave
// - master makes four hunt attempts, toggling
// - lock needs pll lock and sync words
`default_nettype none
`include "sdiltc_cfg.svh"
module sdiltc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        input_one_signal_absent_n,
  input  wire logic        input_two_signal_absent_n,
  input  wire logic        input_choose,
  input  wire logic        master_mode,
  input  wire logic        wide_words,
  input  wire logic        pll_lock,
  input  wire logic        loopthrough_enable,
  input  wire logic        rate_choose_i,
  output logic             rate_choose_o,
  output logic             rate_choose_oe_n,
  input  wire logic        retime_bypass_n_i,
  output logic             retime_bypass_n_o,
  output logic             retime_bypass_n_oe_n,
  input  wire logic        in1_bit,
  input  wire logic        in2_bit,
  input  wire logic        recl_bit,
  input  wire logic        recl_bit_valid,
  input  wire logic        sync_found,
  output logic             in_route_one,
  output logic             lock_indicate,
  output logic             loopthrough_out_p,
  output logic             loopthrough_out_n,
  output logic             loopthrough_oe_n,
  output logic [19:0]      word_data,
  output logic             word_valid,
  input  wire logic        smpte_ready,
  input  wire logic        asi_ready
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [8:0] s1_q, s2_q, pins;
  logic cd1_n, cd2_n, sel, mst, wide, plk, lt_en, rate_in, rb_in;
  assign pins = {input_one_signal_absent_n, input_two_signal_absent_n,
                 input_choose, master_mode, wide_words, pll_lock,
                 loopthrough_enable, rate_choose_i, retime_bypass_n_i};
  assign {cd1_n, cd2_n, sel, mst, wide, plk, lt_en, rate_in, rb_in} = s2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= `SDILTC_SYNC_RST;
      s2_q <= `SDILTC_SYNC_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  // ---------------------------------------------------------------
  // carrier select and lock hunt
  // ---------------------------------------------------------------
  logic carrier_ok, sel_abs_n, lk_ok, buf_bit;
  sdiltc_pkg::sdiltc_lock_t st_q, st_d;
  logic [15:0] dwell_q, dwell_d, cnt_q, cnt_d;
  logic [1:0]  try_q, try_d;
  logic        rate_q, rate_d, rate_eff, lock_q, lock_d;

  assign sel_abs_n  = sel ? cd1_n : cd2_n;
  assign carrier_ok = ~sel_abs_n;
  assign in_route_one = sel;
  assign buf_bit    = sel ? in1_bit : in2_bit;
  assign lk_ok      = plk & sync_found;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    try_d  = try_q;
    rate_d = rate_q;
    unique case (st_q)
      sdiltc_pkg::LS_IDLE: begin
        if (carrier_ok && mst) begin
          st_d  = sdiltc_pkg::LS_HUNT;
          cnt_d = '0;
          try_d = '0;
        end
      end
      sdiltc_pkg::LS_HUNT: begin
        cnt_d = cnt_q + 16'h0001;
        if (lk_ok) begin
          st_d = sdiltc_pkg::LS_LOCK;
        end else if (cnt_q >= dwell_q) begin
          cnt_d  = '0;
          rate_d = ~rate_q;
          if (try_q == `SDILTC_HUNT_TRIES) begin
            st_d = sdiltc_pkg::LS_PLL;
          end else begin
            try_d = try_q + 2'h1;
          end
        end
      end
      sdiltc_pkg::LS_LOCK: begin
        if (!lk_ok) begin
          st_d  = sdiltc_pkg::LS_HUNT;
          cnt_d = '0;
          try_d = '0;
        end
      end
      sdiltc_pkg::LS_PLL: begin
        if (lk_ok) begin
          st_d = sdiltc_pkg::LS_LOCK;
        end
      end
    endcase
    // no carrier or slave mode: park at the SD rate
    if (!carrier_ok || !mst) begin
      st_d   = sdiltc_pkg::LS_IDLE;
      rate_d = `SDILTC_RATE_SD;
    end
    lock_d = carrier_ok &
             (mst ? (st_d == sdiltc_pkg::LS_LOCK) : lk_ok);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= sdiltc_pkg::LS_IDLE;
      cnt_q  <= '0;
      try_q  <= '0;
      rate_q <= `SDILTC_RATE_SD;
      lock_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      try_q  <= try_d;
      rate_q <= rate_d;
      lock_q <= lock_d;
    end
  end

  // ---------------------------------------------------------------
  // pin drive and loop-through
  // ---------------------------------------------------------------
  logic reclocked, mute, lt_p_q, lt_p_d, lt_n_q, lt_n_d;

  assign lock_indicate        = lock_q;
  assign rate_eff             = mst ? rate_q : rate_in;
  assign rate_choose_o        = rate_q;
  assign rate_choose_oe_n     = ~mst;
  // from the hunt state, not lock_q: a slave lock must not leak into
  // the first master cycle after a mode change
  assign retime_bypass_n_o    = mst & (st_q == sdiltc_pkg::LS_LOCK);
  assign retime_bypass_n_oe_n = ~mst;
  assign reclocked = mst ? retime_bypass_n_o : rb_in;
  assign mute = ~carrier_ok |
                (~mst & rb_in & ~lock_q);
  assign loopthrough_oe_n  = ~lt_en;
  assign loopthrough_out_p = lt_p_q;
  assign loopthrough_out_n = lt_n_q;

  always_comb begin
    // static low differential level while muted
    lt_p_d = 1'b0;
    lt_n_d = 1'b1;
    if (!mute) begin
      lt_p_d = reclocked ? recl_bit : buf_bit;
      lt_n_d = ~lt_p_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lt_p_q <= 1'b0;
      lt_n_q <= 1'b1;
    end else begin
      lt_p_q <= lt_p_d;
      lt_n_q <= lt_n_d;
    end
  end

  // ---------------------------------------------------------------
  // word path
  // ---------------------------------------------------------------
  logic [19:0] sp_word;
  logic        sp_valid, sp_ready, sp_drop;

  sdiltc_s2p #(.W(`SDILTC_WORD_W)) u_s2p (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .bit_in     (recl_bit),
    .bit_valid  (recl_bit_valid & lock_q),
    .wide       (wide),
    .word       (sp_word),
    .word_valid (sp_valid),
    .word_ready (sp_ready),
    .drop       (sp_drop)
  );

  // one stream feeds both alignment paths, so both must take it
  sdiltc_fifo #(.W(`SDILTC_WORD_W), .DEPTH(`SDILTC_FIFO_DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (sp_word),
    .in_valid  (sp_valid),
    .in_ready  (sp_ready),
    .out_data  (word_data),
    .out_valid (word_valid),
    .out_ready (smpte_ready & asi_ready)
  );

  // ---------------------------------------------------------------
  // axi4-lite registers
  // ---------------------------------------------------------------
  logic        bv_q, bv_d, rv_q, rv_d, ovf_q, ovf_d, wr, rd;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [31:0] rdat_q, rdat_d;

  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bv_q;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = ~rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rresp   = rr_q;
  assign s_axi_rdata   = rdat_q;
  assign wr = s_axi_awready;
  assign rd = s_axi_arvalid & ~rv_q;

  always_comb begin
    bv_d    = bv_q & ~s_axi_bready;
    br_d    = br_q;
    rv_d    = rv_q & ~s_axi_rready;
    rr_d    = rr_q;
    rdat_d  = rdat_q;
    dwell_d = dwell_q;
    ovf_d   = ovf_q;
    if (wr) begin
      bv_d = 1'b1;
      br_d = `SDILTC_RESP_OK;
      if (s_axi_awaddr == `SDILTC_A_CTRL) begin
        if (s_axi_wstrb[0]) dwell_d[7:0]  = s_axi_wdata[7:0];
        if (s_axi_wstrb[1]) dwell_d[15:8] = s_axi_wdata[15:8];
      end else if (s_axi_awaddr == `SDILTC_A_STATUS) begin
        if (s_axi_wstrb[0] && s_axi_wdata[`SDILTC_OVF_BIT]) ovf_d = 1'b0;
      end else begin
        br_d = `SDILTC_RESP_ERR;
      end
    end
    if (sp_drop) ovf_d = 1'b1;                // set beats clear
    if (rd) begin
      rv_d   = 1'b1;
      rr_d   = `SDILTC_RESP_OK;
      rdat_d = '0;
      if (s_axi_araddr == `SDILTC_A_CTRL) begin
        rdat_d[15:0] = dwell_q;
      end else if (s_axi_araddr == `SDILTC_A_STATUS) begin
        rdat_d[11:0] = {st_q, 1'b0, ovf_q, mst, mute, reclocked,
                        rate_eff, lock_q, carrier_ok};
      end else begin
        rr_d = `SDILTC_RESP_ERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q    <= 1'b0;
      br_q    <= `SDILTC_RESP_OK;
      rv_q    <= 1'b0;
      rr_q    <= `SDILTC_RESP_OK;
      rdat_q  <= '0;
      dwell_q <= `SDILTC_DWELL_RST;
      ovf_q   <= 1'b0;
    end else begin
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rr_q    <= rr_d;
      rdat_q  <= rdat_d;
      dwell_q <= dwell_d;
      ovf_q   <= ovf_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence hunt_step;
    st_q == sdiltc_pkg::LS_HUNT && !lk_ok && cnt_q >= dwell_q &&
    carrier_ok && mst;
  endsequence
  sequence last_step;
    hunt_step ##0 try_q == `SDILTC_HUNT_TRIES;
  endsequence

  a_carrier_sel_mux: assert property (
    carrier_ok == (sel ? !cd1_n : !cd2_n)) else $error("carrier mux");
  a_lock_needs_cd: assert property (
    lock_indicate |-> $past(carrier_ok)) else $error("lock w/o carrier");
  a_mute_static: assert property (
    !carrier_ok |=> !loopthrough_out_p && loopthrough_out_n)
    else $error("not muted");
  a_hiz_disable: assert property (
    loopthrough_oe_n == !lt_en) else $error("oe wrong");
  a_hunt_toggle: assert property (
    hunt_step |=> rate_q != $past(rate_q)) else $error("no toggle");
  a_four_tries: assert property (
    last_step |=> st_q == sdiltc_pkg::LS_PLL) else $error("not pll");
  a_slave_no_drive: assert property (
    !mst |-> rate_choose_oe_n && retime_bypass_n_oe_n)
    else $error("slave drives");
  a_master_bypass: assert property (
    mst && st_q != sdiltc_pkg::LS_LOCK |-> !retime_bypass_n_o)
    else $error("bypass high");
  a_slave_unlock_mute: assert property (
    !mst && rb_in && !lock_q |=> !loopthrough_out_p)
    else $error("slave not muted");
endmodule
`default_nettype wire

// >>> sdiltc_partner.sv
/*
 * far-side model: cable equalizer carrier pins, reclocker lock, serial
 * bits and the two word consumers.
 * assumes the bench sets its controls just after a rising edge.
 */
`default_nettype none
module sdiltc_partner (
  input  wire logic aclk,
  input  wire logic use_one,
  input  wire logic carrier_ok,
  input  wire logic locked,
  input  wire logic stall,
  output logic      cd_one_n,
  output logic      cd_two_n,
  output logic      in1_bit,
  output logic      in2_bit,
  output logic      pll_lock,
  output logic      sync_found,
  output logic      recl_bit,
  output logic      recl_bit_valid,
  output logic      smpte_ready,
  output logic      asi_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cd_one_n, cd_two_n} = 2'h3;
    {in1_bit, in2_bit, pll_lock, sync_found} = 4'h0;
    {recl_bit, recl_bit_valid, smpte_ready, asi_ready} = 4'h0;
  end
  // ---------------------------------------------------------------
  // pin behaviour
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    // the input not in use always reports no carrier
    cd_one_n <= use_one ? !carrier_ok : 1'h1;
    cd_two_n <= use_one ? 1'h1 : !carrier_ok;
    // raw bits toggle so an unmuted buffered copy is never static
    in1_bit <= !in1_bit;
    in2_bit <= !in2_bit;
    pll_lock <= locked;
    sync_found <= locked;
    // all-ones stream: any word alignment yields the same word
    recl_bit <= 1'h1;
    recl_bit_valid <= locked;
    smpte_ready <= !stall;
    asi_ready <= 1'h1;
  end
endmodule
`default_nettype wire

// >>> sdiltc_tb_top.sv
/*
 * self-checking bench for the input select / loop-through block.
 * assumes the partner model and the cfg header constants.
 */
`default_nettype none
`include "sdiltc_cfg.svh"
module sdiltc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr;
  logic [3:0] awa, ara, wst;
  logic [31:0] wd, rd_d;
  logic [1:0] bresp, rresp;
  logic cd1, cd2, choose, mst, wide, pll, en, rate_i, rate_o, rate_oe;
  logic byp_i, byp_o, byp_oe, b1, b2, rb, rbv, sync, route1, lock;
  logic op, on, ooe, wvld, srdy, ardy;
  logic use_one, carrier, locked, stall;
  logic [19:0] wdat;
  int error_cnt, compares;

  sdiltc_partner u_partner (.aclk(aclk), .use_one(use_one),
    .carrier_ok(carrier), .locked(locked), .stall(stall), .cd_one_n(cd1),
    .cd_two_n(cd2), .in1_bit(b1), .in2_bit(b2), .pll_lock(pll),
    .sync_found(sync), .recl_bit(rb), .recl_bit_valid(rbv),
    .smpte_ready(srdy), .asi_ready(ardy));
  sdiltc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .input_one_signal_absent_n(cd1),
    .input_two_signal_absent_n(cd2), .input_choose(choose),
    .master_mode(mst), .wide_words(wide), .pll_lock(pll),
    .loopthrough_enable(en), .rate_choose_i(rate_i),
    .rate_choose_o(rate_o), .rate_choose_oe_n(rate_oe),
    .retime_bypass_n_i(byp_i), .retime_bypass_n_o(byp_o),
    .retime_bypass_n_oe_n(byp_oe), .in1_bit(b1), .in2_bit(b2),
    .recl_bit(rb), .recl_bit_valid(rbv), .sync_found(sync),
    .in_route_one(route1), .lock_indicate(lock), .loopthrough_out_p(op),
    .loopthrough_out_n(on), .loopthrough_oe_n(ooe), .word_data(wdat),
    .word_valid(wvld), .smpte_ready(srdy), .asi_ready(ardy));

  initial begin
    aclk = 1'h0;
    forever #4 aclk = !aclk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awa <= a;
    wd <= d;
    wst <= 4'hF;
    awv <= 1'h1;
    wv <= 1'h1;
    @(posedge aclk);
    while (awr !== 1'h1 || wr_r !== 1'h1) @(posedge aclk);
    awv <= 1'h0;
    wv <= 1'h0;
    br <= 1'h1;
    @(posedge aclk);
    while (bv !== 1'h1) @(posedge aclk);
    r = bresp;
    br <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    ara <= a;
    arv <= 1'h1;
    @(posedge aclk);
    while (arr !== 1'h1) @(posedge aclk);
    arv <= 1'h0;
    rr <= 1'h1;
    @(posedge aclk);
    while (rv !== 1'h1) @(posedge aclk);
    d = rd_d;
    r = rresp;
    rr <= 1'h0;
  endtask
  task automatic st(output logic [31:0] d);
    logic [1:0] r;
    rd(`SDILTC_A_STATUS, d, r);
  endtask
  // muted means a static p low / n high for several cycles
  task automatic chk_mute(input logic e, input string m);
    logic q;
    q = 1'h1;
    repeat (6) begin
      @(posedge aclk);
      if (!(op === 1'h0 && on === 1'h1)) q = 1'h0;
    end
    chk(q, e, m);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk({lock, op, on, rate_o}, 4'h3, "reset outputs");
    rd(`SDILTC_A_CTRL, d, r);
    chk(d, `SDILTC_DWELL_RST, "ctrl reset");
    rd(4'h8, d, r);
    chk(r, `SDILTC_RESP_ERR, "unmapped read");
    wr(4'hC, 32'h0000_0001, r);
    chk(r, `SDILTC_RESP_ERR, "unmapped write");
    wr(`SDILTC_A_CTRL, 32'h0000_0004, r);
    rd(`SDILTC_A_CTRL, d, r);
    chk({r, d[15:0]}, 18'h00004, "ctrl dwell");
    $display("test regs done");
  endtask
  task automatic t_slave();
    logic [31:0] d;
    {mst, en, use_one, choose, carrier, byp_i, locked} <= 7'h3C;
    tick(6);
    chk(route1, 1'h1, "route one");
    chk({rate_oe, byp_oe}, 2'h3, "slave pins input");
    chk_mute(1'h0, "buffered unmuted");
    rate_i <= 1'h1;
    tick(6);
    st(d);
    chk(d[2], 1'h1, "slave rate follows pin high");
    rate_i <= 1'h0;
    tick(6);
    st(d);
    chk(d[2], 1'h0, "slave rate follows pin");
    byp_i <= 1'h1;
    tick(4);
    chk_mute(1'h1, "reclocked unlocked mute");
    locked <= 1'h1;
    tick(8);
    chk(lock, 1'h1, "slave lock");
    chk_mute(1'h0, "reclocked locked");
    carrier <= 1'h0;
    tick(6);
    chk(lock, 1'h0, "carrier forces unlock");
    chk_mute(1'h1, "no carrier mute");
    {carrier, choose} <= 2'h2;
    tick(6);
    chk(route1, 1'h0, "route two");
    chk_mute(1'h1, "other carrier selected");
    en <= 1'h0;
    tick(6);
    chk(ooe, 1'h1, "output high impedance");
    {en, choose, locked} <= 3'h6;
    $display("test slave done");
  endtask
  task automatic t_hunt();
    logic [31:0] d;
    logic p;
    int n;
    {mst, carrier} <= 2'h2;
    tick(8);
    chk({rate_oe, byp_oe, rate_o}, 3'h1, "master drives pins");
    carrier <= 1'h1;
    n = 0;
    p = rate_o;
    repeat (26) begin
      @(posedge aclk);
      if (rate_o !== p) n++;
      p = rate_o;
    end
    chk(n, 4, "hunt toggles");
    st(d);
    chk(d[11:8], 4'h8, "pll after four tries");
    $display("test hunt done");
  endtask
  task automatic t_lock();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    carrier <= 1'h0;
    tick(6);
    {locked, carrier} <= 2'h3;
    tick(20);
    chk({lock, byp_o}, 2'h3, "master locked");
    st(d);
    chk(d[11:8], 4'h4, "lock state");
    tick(30);
    // a word stands one cycle in ten, so wait for it
    while (wvld !== 1'h1) @(posedge aclk);
    chk({wvld, wdat}, 21'h1003FF, "narrow word");
    wide <= 1'h1;
    tick(60);
    while (wvld !== 1'h1) @(posedge aclk);
    chk(wdat, 20'hFFFFF, "wide word");
    stall <= 1'h1;
    tick(450);
    st(d);
    chk({wvld, d[`SDILTC_OVF_BIT]}, 2'h3, "fifo full, overflow");
    stall <= 1'h0;
    n = 0;
    tick(1);
    while (wvld === 1'h1 && n < 40) begin
      n++;
      @(posedge aclk);
    end
    chk(n >= 16 && n < 40, 1'h1, "fifo drained");
    wr(`SDILTC_A_STATUS, 32'h0000_0040, r);
    st(d);
    chk(d[`SDILTC_OVF_BIT], 1'h0, "overflow cleared");
    carrier <= 1'h0;
    tick(6);
    chk({lock, byp_o}, 2'h0, "carrier lost");
    chk_mute(1'h1, "master mute");
    $display("test lock done");
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {aresetn, awv, wv, br, arv, rr, awa, ara, wst, wd} = '0;
    {choose, mst, wide, en, rate_i, byp_i} = 6'h10;
    {use_one, carrier, locked, stall} = 4'h8;
    error_cnt = 0;
    compares = 0;
    tick(10);
    aresetn <= 1'h1;
    tick(1);
    t_regs();
    t_slave();
    t_hunt();
    t_lock();
    conclude();
  end
  initial begin
    tick(20000);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire
